/* logic/rst_seq_mgr.sv */
module rst_seq_mgr import rst_seq_pkg::*; #(
   parameter int ACTIVE_CYCLES = 16,
   parameter int OSC_DIV       = 1
) (
   input  wire logic              CORE_CLK,
   input  wire logic              RST_N,
   input  wire logic              HSEL,
   input  wire logic [31:0]       HADDR,
   input  wire logic [1:0]        HTRANS,
   input  wire logic              HWRITE,
   input  wire logic [2:0]        HSIZE,
   input  wire logic [31:0]       HWDATA,
   input  wire logic              HREADY,
   output logic      [31:0]       HRDATA,
   output logic                   HREADYOUT,
   output logic                   HRESP,
   input  wire logic              RESET_PIN_IN,
   output logic                   RESET_PIN_OUT,
   output logic                   RESET_PIN_OE_N,
   input  wire logic              LOW_VOLTAGE_DETECT,
   input  wire logic [OPT_W-1:0]  OPTION_BYTE,
   input  wire logic              HALT_REQ,
   input  wire logic [7:0]        FETCH_DATA,
   output logic [15:0]            FETCH_ADDR,
   output logic                   FETCH_RD,
   output logic [15:0]            RESET_VECTOR,
   output logic                   CORE_RESET_N,
   output logic                   OSC_ENABLE,
   output logic [OPT_CLK_W-1:0]   OSC_SOURCE,
   output logic                   PLL_ENABLE
);

   localparam logic [DLY_W-1:0] ACT_LAST = DLY_W'(ACTIVE_CYCLES - 1);
   localparam logic [15:0]      DIV_LAST = 16'(OSC_DIV - 1);

   // ==========================================================
   // Declarations
   // ==========================================================
   phase_e            phase_reg;
   phase_e            phase_next;
   source_e           src_reg;
   source_e           src_next;
   logic [DLY_W-1:0]  cnt_reg;
   logic [DLY_W-1:0]  cnt_next;
   logic [DLY_W-1:0]  delay_len;
   logic [2:0]        guard_reg;
   logic              ext_catch_reg;
   logic              catch_q;
   logic              pin_q;
   logic              uv_q;
   logic              ext_req;
   logic [OPT_W-1:0]  opt_reg;
   logic              opt_taken_reg;
   logic [CNT_W-1:0]  count_value_reg;
   logic              wdg_en_reg;
   logic [TB_W-1:0]   timebase_reg;
   logic [TO_W-1:0]   wdg_cnt_reg;
   logic [TO_W-1:0]   tmin_reg;
   logic [TO_W-1:0]   tmax_reg;
   logic [TO_W-1:0]   t_min;
   logic [TO_W-1:0]   t_max;
   logic [15:0]       div_reg;
   logic              osc_tick;
   logic              wdg_expire;
   logic              wdg_reload;
   logic [CAUSE_W-1:0] cause_reg;
   logic [CAUSE_W-1:0] cause_set;
   logic [CAUSE_W-1:0] cause_clr;
   logic [15:0]       fetch_addr_reg;
   logic [15:0]       vector_reg;
   logic              ap_valid_reg;
   logic              ap_write_reg;
   logic [ADDR_W-1:0] ap_addr_reg;
   logic [31:0]       hrdata_reg;
   logic [31:0]       rdata;
   logic              addr_phase;
   logic              wr_en;

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   sync3 #(.INIT(1'b1)) u_pin_sync (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .d     (RESET_PIN_IN),
      .q     (pin_q)
   );

   sync3 #(.INIT(1'b0)) u_uv_sync (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .d     (LOW_VOLTAGE_DETECT),
      .q     (uv_q)
   );

   sync3 #(.INIT(1'b0)) u_catch_sync (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .d     (ext_catch_reg),
      .q     (catch_q)
   );

   // ==========================================================
   // Asynchronous capture of an external pulse
   // ==========================================================
   // Set straight from the pin so a stopped clock cannot hide it
   always_ff @(posedge CORE_CLK or negedge RST_N or negedge RESET_PIN_IN) begin
      if (!RST_N) begin
         ext_catch_reg <= 1'b0;
      end else if (!RESET_PIN_IN) begin
         ext_catch_reg <= 1'b1;
      end else if (phase_reg != PH_RUN) begin
         ext_catch_reg <= 1'b0;
      end
   end

   // Stale synchroniser ones from our own drive are ignored for a few cycles
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         guard_reg <= 3'h0;
      end else if (phase_reg != PH_RUN) begin
         guard_reg <= 3'h0;
      end else if (guard_reg != RUN_GUARD) begin
         guard_reg <= guard_reg + 3'h1;
      end
   end

   // Short glitches may still be taken; width is the driver's duty
   assign ext_req = catch_q && (guard_reg == RUN_GUARD);

   // ==========================================================
   // Option byte, caught once after reset release
   // ==========================================================
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         opt_reg       <= '0;
         opt_taken_reg <= 1'b0;
      end else if (!opt_taken_reg) begin
         opt_reg       <= OPTION_BYTE;
         opt_taken_reg <= 1'b1;
      end
   end

   assign delay_len = opt_reg[OPT_LONG_BIT] ? DELAY_LONG : DELAY_SHORT;
   assign OSC_SOURCE = opt_reg[OPT_CLK_LSB +: OPT_CLK_W];
   assign PLL_ENABLE = opt_reg[OPT_PLL_BIT] && (OSC_SOURCE != CLK_RC);

   // ==========================================================
   // Reset sequencer
   // ==========================================================
   always_comb begin
      phase_next = phase_reg;
      src_next   = src_reg;
      cnt_next   = cnt_reg;
      unique case (phase_reg)
         PH_RUN: begin
            if (ext_req) begin
               phase_next = PH_ACTIVE;
               src_next   = SRC_EXT;
               cnt_next   = '0;
            end else if (uv_q) begin
               phase_next = PH_ACTIVE;
               src_next   = SRC_UV;
               cnt_next   = '0;
            end else if (wdg_expire) begin
               phase_next = PH_ACTIVE;
               src_next   = SRC_WDG;
               cnt_next   = '0;
            end
         end
         PH_ACTIVE: begin
            // External source lasts as long as the pin is held low
            if (src_reg == SRC_EXT) begin
               if (pin_q) begin
                  phase_next = PH_DELAY;
                  cnt_next   = '0;
               end
            end else if (uv_q) begin
               cnt_next = '0;
            end else if (cnt_reg == ACT_LAST) begin
               phase_next = PH_DELAY;
               cnt_next   = '0;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         PH_DELAY: begin
            if (uv_q) begin
               phase_next = PH_ACTIVE;
               src_next   = SRC_UV;
               cnt_next   = '0;
            end else if (cnt_reg == delay_len - 1'b1) begin
               phase_next = PH_FETCH;
               cnt_next   = '0;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         PH_FETCH: begin
            if (cnt_reg == FETCH_CYCLES - 1'b1) begin
               phase_next = PH_RUN;
               cnt_next   = '0;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         phase_reg <= PH_ACTIVE;
         src_reg   <= SRC_POR;
         cnt_reg   <= '0;
      end else begin
         phase_reg <= phase_next;
         src_reg   <= src_next;
         cnt_reg   <= cnt_next;
      end
   end

   // ==========================================================
   // Pin, core reset and oscillator control
   // ==========================================================
   assign RESET_PIN_OUT  = 1'b0;
   // Internal sources pull the pin during active phase too
   assign RESET_PIN_OE_N = !((phase_reg == PH_DELAY) ||
                             (phase_reg == PH_ACTIVE && src_reg != SRC_EXT));
   assign CORE_RESET_N   = (phase_reg == PH_RUN) && !ext_catch_reg;
   // Only halt stops the oscillator; a pin pulse wakes it at once
   assign OSC_ENABLE     = !((phase_reg == PH_RUN) && HALT_REQ && !ext_catch_reg);

   // ==========================================================
   // Reset vector fetch
   // ==========================================================
   // Memory answers FETCH_ADDR combinationally in the same cycle
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         fetch_addr_reg <= VEC_HI_ADDR;
         vector_reg     <= 16'h0000;
      end else if (phase_reg == PH_FETCH) begin
         if (cnt_reg == '0) begin
            vector_reg[15:8] <= FETCH_DATA;
            fetch_addr_reg   <= VEC_LO_ADDR;
         end else begin
            vector_reg[7:0]  <= FETCH_DATA;
            fetch_addr_reg   <= VEC_HI_ADDR;
         end
      end
   end

   assign FETCH_ADDR   = fetch_addr_reg;
   assign FETCH_RD     = (phase_reg == PH_FETCH);
   assign RESET_VECTOR = vector_reg;

   // ==========================================================
   // Watchdog timeout
   // ==========================================================
   wdg_timeout_calc u_calc (
      .count_value     (count_value_reg),
      .timebase_select (timebase_reg),
      .t_min           (t_min),
      .t_max           (t_max)
   );

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tmin_reg <= '0;
         tmax_reg <= '0;
      end else begin
         tmin_reg <= t_min;
         tmax_reg <= t_max;
      end
   end

   // Oscillator period as an enable pulse
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_reg <= 16'h0000;
      end else if (osc_tick) begin
         div_reg <= 16'h0000;
      end else begin
         div_reg <= div_reg + 16'h0001;
      end
   end

   assign osc_tick   = (div_reg == DIV_LAST);
   assign wdg_reload = wr_en && (ap_addr_reg == OFF_WDG_CTRL);
   // Trips at the minimum timeout, the earliest legal point
   assign wdg_expire = wdg_en_reg && osc_tick && (wdg_cnt_reg >= tmin_reg - 1'b1);

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wdg_cnt_reg <= '0;
      end else if (phase_reg != PH_RUN || wdg_reload) begin
         wdg_cnt_reg <= '0;
      end else if (wdg_en_reg && osc_tick) begin
         wdg_cnt_reg <= wdg_cnt_reg + 1'b1;
      end
   end

   // Software can start the watchdog but never stop it
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wdg_en_reg      <= 1'b0;
         count_value_reg <= '0;
      end else if (phase_reg != PH_RUN) begin
         wdg_en_reg      <= 1'b0;
      end else if (wdg_reload) begin
         wdg_en_reg      <= wdg_en_reg | HWDATA[WDG_EN_BIT];
         count_value_reg <= HWDATA[CNT_W-1:0];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         timebase_reg <= '0;
      end else if (wr_en && ap_addr_reg == OFF_TIMEBASE) begin
         timebase_reg <= HWDATA[TB_W-1:0];
      end
   end

   // ==========================================================
   // Reset cause flags, write one to clear, set wins
   // ==========================================================
   assign cause_set = (phase_reg != PH_ACTIVE && phase_next == PH_ACTIVE) ?
                      (CAUSE_W'(1) << src_next) : '0;
   assign cause_clr = (wr_en && ap_addr_reg == OFF_CAUSE) ? HWDATA[CAUSE_W-1:0] : '0;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cause_reg <= CAUSE_RESET;
      end else begin
         cause_reg <= (cause_reg & ~cause_clr) | cause_set;
      end
   end

   // ==========================================================
   // AHB-Lite slave, zero wait states
   // ==========================================================
   assign addr_phase = HSEL && HREADY && HTRANS[1];
   assign wr_en      = ap_valid_reg && ap_write_reg;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ap_valid_reg <= 1'b0;
         ap_write_reg <= 1'b0;
         ap_addr_reg  <= '0;
      end else if (HREADY) begin
         ap_valid_reg <= addr_phase;
         ap_write_reg <= HWRITE;
         ap_addr_reg  <= HADDR[ADDR_W-1:0];
      end
   end

   // Unmapped offsets read zero and ignore writes
   always_comb begin
      rdata = 32'h0000_0000;
      unique case (HADDR[ADDR_W-1:0])
         OFF_WDG_CTRL: rdata = 32'({wdg_en_reg, count_value_reg});
         OFF_TIMEBASE: rdata = 32'(timebase_reg);
         OFF_CAUSE:    rdata = 32'(cause_reg);
         OFF_OPTION:   rdata = 32'(opt_reg);
         OFF_TMIN:     rdata = 32'(tmin_reg);
         OFF_TMAX:     rdata = 32'(tmax_reg);
         OFF_VECTOR:   rdata = 32'(vector_reg);
         OFF_PHASE:    rdata = 32'({src_reg, phase_reg});
         default:      rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (addr_phase && !HWRITE) begin
         hrdata_reg <= rdata;
      end
   end

   assign HRDATA    = hrdata_reg;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

endmodule : rst_seq_mgr

/* include/rst_seq_pkg.sv */
package rst_seq_pkg;

   // ==========================================================
   // Register map, byte offsets within the slave window
   // ==========================================================
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] OFF_WDG_CTRL = 8'h00;
   localparam logic [7:0] OFF_TIMEBASE = 8'h04;
   localparam logic [7:0] OFF_CAUSE    = 8'h08;
   localparam logic [7:0] OFF_OPTION   = 8'h0C;
   localparam logic [7:0] OFF_TMIN     = 8'h10;
   localparam logic [7:0] OFF_TMAX     = 8'h14;
   localparam logic [7:0] OFF_VECTOR   = 8'h18;
   localparam logic [7:0] OFF_PHASE    = 8'h1C;

   // ==========================================================
   // Fields and reset values
   // ==========================================================
   localparam int         CNT_W       = 6;
   localparam int         WDG_EN_BIT  = 6;
   localparam int         TB_W        = 2;
   localparam int         CAUSE_W     = 4;
   localparam logic [3:0] CAUSE_RESET = 4'h1;
   localparam int         OPT_W       = 8;
   localparam int         OPT_LONG_BIT = 0;
   localparam int         OPT_CLK_LSB  = 1;
   localparam int         OPT_CLK_W    = 3;
   localparam int         OPT_PLL_BIT  = 4;
   localparam logic [2:0] CLK_EXT      = 3'h0;
   localparam logic [2:0] CLK_RC       = 3'h5;

   // ==========================================================
   // Sequence timing
   // ==========================================================
   localparam int          DLY_W        = 13;
   localparam logic [12:0] DELAY_SHORT  = 13'h0100;
   localparam logic [12:0] DELAY_LONG   = 13'h1000;
   localparam logic [12:0] FETCH_CYCLES = 13'h0002;
   localparam logic [15:0] VEC_HI_ADDR  = 16'hFFFE;
   localparam logic [15:0] VEC_LO_ADDR  = 16'hFFFF;
   localparam logic [2:0]  RUN_GUARD    = 3'h5;

   // ==========================================================
   // Watchdog timeout constants, per timebase select
   // ==========================================================
   localparam int          TO_W         = 22;
   localparam logic [7:0]  WDG_MSB [4]  = '{8'h04, 8'h08, 8'h14, 8'h31};
   localparam logic [7:0]  WDG_LSB [4]  = '{8'h3B, 8'h35, 8'h23, 8'h36};
   localparam logic [21:0] TO_UNIT      = 22'h004000;
   localparam logic [21:0] TO_MAX_BASE  = 22'h004000;
   localparam logic [21:0] TO_MIN_BASE  = 22'h000080;
   localparam logic [21:0] TO_SLOT_BASE = 22'h0000C0;
   localparam logic [21:0] TO_SCALE     = 22'h000040;

   typedef enum logic [1:0] {PH_ACTIVE, PH_DELAY, PH_FETCH, PH_RUN} phase_e;
   typedef enum logic [1:0] {SRC_POR, SRC_EXT, SRC_UV, SRC_WDG} source_e;

endpackage : rst_seq_pkg

/* logic/sync3.sv */
module sync3 import rst_seq_pkg::*; #(
   parameter logic INIT = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic d,
   output logic      q
);

   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Only a level seen by two stages in a row is taken
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= INIT;
      end else if (s2 == s3) begin
         q <= s2;
      end
   end

endmodule : sync3

/* logic/wdg_timeout_calc.sv */
module wdg_timeout_calc import rst_seq_pkg::*; (
   input  wire logic [CNT_W-1:0] count_value,
   input  wire logic [TB_W-1:0]  timebase_select,
   output logic      [TO_W-1:0]  t_min,
   output logic      [TO_W-1:0]  t_max
);

   logic [7:0]      msb;
   logic [7:0]      lsb;
   logic [7:0]      cnt8;
   logic [7:0]      quot;
   logic [7:0]      thr;
   logic [TO_W-1:0] linear;
   logic [TO_W-1:0] above;
   logic [TO_W-1:0] base_min;

   always_comb begin
      msb      = WDG_MSB[timebase_select];
      lsb      = WDG_LSB[timebase_select];
      cnt8     = 8'(count_value);
      // Integer division truncates, as the timeout needs
      quot     = 8'({count_value, 2'b00} / msb);
      thr      = msb >> 2;
      base_min = (TO_MIN_BASE + TO_W'(lsb)) * TO_SCALE;
      linear   = TO_UNIT * TO_W'(cnt8);
      above    = TO_UNIT * (TO_W'(cnt8) - TO_W'(quot))
               + (TO_SLOT_BASE + TO_W'(lsb)) * TO_SCALE * TO_W'(quot);
      // Minimum uses a strict threshold, maximum an inclusive one
      t_min    = base_min + ((cnt8 < thr) ? linear : above);
      t_max    = TO_MAX_BASE + ((cnt8 <= thr) ? linear : above);
   end

endmodule : wdg_timeout_calc

/* sim/rst_seq_checker.sv */
// ==========================================
// Port checks of the reset sequencer
// ==========================================
module rst_seq_checker import rst_seq_pkg::*; (
   input wire logic                 CORE_CLK,
   input wire logic                 RST_N,
   input wire logic                 RESET_PIN_IN,
   input wire logic                 RESET_PIN_OUT,
   input wire logic                 RESET_PIN_OE_N,
   input wire logic [7:0]           FETCH_DATA,
   input wire logic [15:0]          FETCH_ADDR,
   input wire logic                 FETCH_RD,
   input wire logic [15:0]          RESET_VECTOR,
   input wire logic                 CORE_RESET_N,
   input wire logic                 OSC_ENABLE,
   input wire logic [OPT_CLK_W-1:0] OSC_SOURCE,
   input wire logic                 PLL_ENABLE
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [12:0] low_reg;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // Saturates so a stuck drive cannot wrap back under the delay bound
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N)
         low_reg <= 13'h0000;
      else if (RESET_PIN_OE_N)
         low_reg <= 13'h0000;
      else if (low_reg != 13'h1FFF)
         low_reg <= low_reg + 13'h0001;
   end
   pin_open_drain_a: assert property (RESET_PIN_OUT == 1'b0)
      else $error("reset pin output drives high");
   async_catch_a: assert property (!RESET_PIN_IN |-> !CORE_RESET_N)
      else $error("pin low while core runs");
   internal_drive_a: assert property ($fell(CORE_RESET_N) |-> !RESET_PIN_IN)
      else $error("reset entered without pin low");
   delay_drive_a: assert property ($rose(FETCH_RD) |-> low_reg >= 13'h0100)
      else $error("pin drive shorter than delay");
   fetch_walk_a: assert property ($rose(FETCH_RD) |-> (FETCH_ADDR == VEC_HI_ADDR)
      ##1 (FETCH_RD && FETCH_ADDR == VEC_LO_ADDR) ##1 !FETCH_RD) else $error("bad fetch");
   vector_load_a: assert property ($fell(FETCH_RD)
      |-> RESET_VECTOR == {$past(FETCH_DATA, 2), $past(FETCH_DATA)}) else $error("bad vector");
   fetch_then_run_a: assert property ($rose(CORE_RESET_N)
      |-> $past(FETCH_RD) && RESET_PIN_OE_N) else $error("run entered without fetch");
   osc_kept_a: assert property (!CORE_RESET_N |-> OSC_ENABLE)
      else $error("oscillator stopped in reset");
   pll_rc_a: assert property (PLL_ENABLE |-> OSC_SOURCE != CLK_RC)
      else $error("PLL with RC source");
   cover property ($rose(FETCH_RD));
   cover property (!RESET_PIN_IN && RESET_PIN_OE_N);
   cover property ($fell(CORE_RESET_N) && !RESET_PIN_OE_N);
endmodule : rst_seq_checker

bind rst_seq_mgr rst_seq_checker rst_seq_checker_inst (.CORE_CLK, .RST_N, .RESET_PIN_IN,
   .RESET_PIN_OUT, .RESET_PIN_OE_N, .FETCH_DATA, .FETCH_ADDR, .FETCH_RD, .RESET_VECTOR,
   .CORE_RESET_N, .OSC_ENABLE, .OSC_SOURCE, .PLL_ENABLE);

/* sim/ext_reset_src.sv */
// ==========================================
// External circuit on the open-drain reset pin
// ==========================================
module ext_reset_src (
   input  wire logic pull_low,
   input  wire logic dev_oe_n,
   output logic      pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Weak pull-up wins only when neither side sinks the pin
   assign pin_level = !(pull_low || !dev_oe_n);
endmodule : ext_reset_src

/* sim/testbench.sv */
module testbench import rst_seq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, rst_n, hsel, hwrite, low_v, halt, pull, hready, pin, oe_n;
   logic        core_rst_n, fetch_rd, osc_en, pll_en, hresp;
   logic [1:0]  htrans;
   logic [2:0]  osc_src;
   logic [7:0]  opt, fetch_data;
   logic [15:0] fetch_addr, vector;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          fail_count, comparisons, m, n;
   int          cnts [5] = '{0, 1, 2, 12, 63};

   // Boot memory answers in the same cycle
   assign fetch_data = (fetch_addr == VEC_HI_ADDR) ? 8'hA5 : 8'h3C;

   ext_reset_src ext_reset_src_inst (.pull_low(pull), .dev_oe_n(oe_n), .pin_level(pin));

   rst_seq_mgr #(.ACTIVE_CYCLES(4), .OSC_DIV(1)) rst_seq_mgr_inst (.CORE_CLK(core_clk),
      .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
      .HRESP(hresp), .RESET_PIN_IN(pin), .RESET_PIN_OUT(), .RESET_PIN_OE_N(oe_n),
      .LOW_VOLTAGE_DETECT(low_v), .OPTION_BYTE(opt), .HALT_REQ(halt), .FETCH_DATA(fetch_data),
      .FETCH_ADDR(fetch_addr), .FETCH_RD(fetch_rd), .RESET_VECTOR(vector),
      .CORE_RESET_N(core_rst_n), .OSC_ENABLE(osc_en), .OSC_SOURCE(osc_src),
      .PLL_ENABLE(pll_en));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ==========================================
   // Checking and closing
   // ==========================================
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [31:0] tmo(input int c, input int t, input bit mx);
      int msb [4] = '{4, 8, 20, 49};
      int lsb [4] = '{59, 53, 35, 54};
      int q;
      int r;
      q = (4 * c) / msb[t];
      r = mx ? 16384 : (lsb[t] + 128) * 64;
      if (mx ? c <= msb[t] / 4 : c < msb[t] / 4)
         r += 16384 * c;
      else
         r += 16384 * (c - q) + (192 + lsb[t]) * 64 * q;
      return 32'(r);
   endfunction : tmo

   // ==========================================
   // Bus and sequence helpers
   // ==========================================
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int k = 0;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsel   <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge core_clk);
         k++;
      end while (hready !== 1'b1 && k < 100);
      rd = hrdata;
      if (k >= 100) begin
         fail_count++;
         stop_test();
      end
   endtask : bus

   task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h00000000);
      check(rd, exp);
   endtask : expect_reg

   task automatic wait_run(output int to_low, output int to_high);
      to_low = 0;
      to_high = 0;
      while (core_rst_n !== 1'b0 && to_low < 20000) begin
         @(posedge core_clk);
         to_low++;
      end
      while (core_rst_n !== 1'b1 && to_high < 20000) begin
         @(posedge core_clk);
         to_high++;
      end
      if (to_low >= 20000 || to_high >= 20000) begin
         fail_count++;
         stop_test();
      end
   endtask : wait_run

   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      {rst_n, hsel, hwrite, low_v, halt, pull} = 6'h00;
      htrans = 2'h0;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      opt = 8'h0A;
      fail_count = 0;
      comparisons = 0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      wait_run(m, n);
      check(32'(n >= 262 && n <= 268), 32'h1);
      check(32'(osc_src), 32'h5);
      check(32'(pll_en), 32'h0);
      check(32'(vector), 32'h0000A53C);
      expect_reg(OFF_CAUSE, 32'h1);
      expect_reg(OFF_PHASE, 32'h3);
      check(32'(hresp), 32'h0);
      expect_reg(OFF_OPTION, 32'h0A);
      expect_reg(OFF_VECTOR, 32'hA53C);
      bus(OFF_CAUSE, 1'b1, 32'h0000000F);
      expect_reg(OFF_CAUSE, 32'h0);
      expect_reg(8'h40, 32'h0);
      for (int t = 0; t < 4; t++) begin
         bus(OFF_TIMEBASE, 1'b1, 32'(t));
         foreach (cnts[i]) begin
            bus(OFF_WDG_CTRL, 1'b1, 32'(cnts[i]));
            // Limits follow a new count one cycle later
            @(posedge core_clk);
            expect_reg(OFF_TMIN, tmo(cnts[i], t, 1'b0));
            expect_reg(OFF_TMAX, tmo(cnts[i], t, 1'b1));
         end
      end
      low_v <= 1'b1;
      repeat (4) @(posedge core_clk);
      low_v <= 1'b0;
      wait_run(m, n);
      expect_reg(OFF_CAUSE, 32'h4);
      expect_reg(OFF_PHASE, 32'hB);
      bus(OFF_CAUSE, 1'b1, 32'h0000000F);
      halt <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(32'(osc_en), 32'h0);
      pull <= 1'b1;
      @(posedge core_clk);
      @(posedge core_clk);
      check(32'({core_rst_n, osc_en}), 32'h1);
      // Held well beyond the shortest pulse the pin must catch
      repeat (10) @(posedge core_clk);
      pull <= 1'b0;
      halt <= 1'b0;
      wait_run(m, n);
      expect_reg(OFF_CAUSE, 32'h2);
      expect_reg(OFF_PHASE, 32'h7);
      bus(OFF_CAUSE, 1'b1, 32'h0000000F);
      bus(OFF_TIMEBASE, 1'b1, 32'h0);
      bus(OFF_WDG_CTRL, 1'b1, 32'h00000040);
      wait_run(m, n);
      check(32'(m >= 11962 && m <= 11974), 32'h1);
      expect_reg(OFF_CAUSE, 32'h8);
      expect_reg(OFF_PHASE, 32'hF);
      rst_n <= 1'b0;
      opt <= 8'h13;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      wait_run(m, n);
      check(32'(n >= 4102 && n <= 4108), 32'h1);
      check(32'({pll_en, osc_src}), 32'h9);
      stop_test();
   end
endmodule : testbench
